/* File: hw/gpc_pkg.sv */
package gpc_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;
  // register offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_STAT  = 8'h04;
  localparam logic [7:0] OFS_ERROR_CONTROL_REG  = 8'h08;
  localparam logic [7:0] OFS_PWR   = 8'h0C;
  localparam logic [7:0] OFS_PM    = 8'h10;
  localparam logic [7:0] OFS_RXBUF = 8'h14;
  localparam logic [7:0] OFS_FIFO  = 8'h18;
  localparam logic [7:0] OFS_FILT  = 8'h1C;
  localparam logic [7:0] OFS_MTA   = 8'h20;
  // field positions
  localparam int CTRL_SRST = 0;
  localparam int CTRL_SPD  = 1;
  localparam int CTRL_HALF = 3;
  localparam int CTRL_SB   = 4;
  localparam int ERROR_CONTROL_REG_URD  = 0;
  localparam int PWR_AG3   = 0;
  localparam int PWR_SX    = 1;
  localparam int PWR_DC    = 2;
  localparam int PWR_ME    = 3;
  localparam int PWR_DIS   = 4;
  localparam int PWR_LOW   = 5;
  localparam int FLT_UC    = 0;
  localparam int FLT_MC    = 1;
  localparam int FLT_BC    = 2;
  localparam int FLT_PRM   = 3;
  localparam int FLT_RSS   = 4;
  // speeds and system states
  localparam logic [1:0] SPD_10   = 2'h0;
  localparam logic [1:0] SPD_100  = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  localparam logic [1:0] SYS_S0   = 2'h0;
  localparam logic [1:0] SYS_S0IX = 2'h1;
  localparam logic [1:0] SYS_SX   = 2'h2;
  // completion status codes
  localparam logic [2:0] CPL_SC  = 3'h0;
  localparam logic [2:0] CPL_UR  = 3'h1;
  localparam logic [2:0] CPL_CRS = 3'h2;
  localparam logic [2:0] CPL_CA  = 3'h4;
  // sizes and limits
  localparam logic [6:0]  MAX_REQ   = 7'h40;
  localparam logic [12:0] PAGE_SZ   = 13'h1000;
  localparam logic [14:0] RXBUF_MIN = 15'h0100;
  localparam logic [14:0] RXBUF_MAX = 15'h4000;
  localparam logic [5:0]  PBUF_KB   = 6'h20;
  localparam logic [13:0] MAX_FRAME = 14'h233A;
  localparam int unsigned HS_TX_MBPS = 1250;
  // reset values
  localparam logic [1:0]  RST_SPD   = SPD_1000;
  localparam logic [14:0] RST_RXBUF = 15'h0800;
  localparam logic [5:0]  RST_RXKB  = 6'h10;
  localparam logic [4:0]  RST_FILT  = 5'h05;
  // sideband clock half periods
  localparam int unsigned SB_HZ0 = 100_000;
  localparam int unsigned SB_HZ1 = 400_000;
  localparam int unsigned SB_HZ2 = 1_000_000;
  localparam logic [6:0] SB_HP0 = 7'(CLK_HZ / (2 * SB_HZ0));
  localparam logic [6:0] SB_HP1 = 7'(CLK_HZ / (2 * SB_HZ1));
  localparam logic [6:0] SB_HP2 = 7'(CLK_HZ / (2 * SB_HZ2));
endpackage

/* File: hw/gpc_gbe_ctrl.sv */
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module gpc_gbe_ctrl
  import gpc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        nvm_done,
  input  wire logic        nvm_port_en,
  input  wire logic        req_valid,
  input  wire logic [63:0] req_addr,
  input  wire logic [15:0] req_len,
  output logic             req_ready,
  output logic             mem_valid,
  output logic      [63:0] mem_addr,
  output logic      [6:0]  mem_len,
  input  wire logic        mem_ready,
  input  wire logic        rx_valid,
  input  wire logic        rx_cfg,
  input  wire logic        rx_np,
  input  wire logic        rx_bad,
  input  wire logic        rx_unsup,
  output logic             cpl_valid,
  output logic      [2:0]  cpl_status,
  output logic             rx_pass,
  input  wire logic [1:0]  sys_state,
  input  wire logic        suspend_to_ram_sleep_n_n_pin,
  input  wire logic        mgmt_sleep_n_n_pin,
  input  wire logic        on_battery_pin,
  input  wire logic        wake_n_pin,
  output logic             lan_phy_sleep_n,
  output logic             phy_power_control_out,
  output logic             hs_link_active,
  output logic             sb_link_active,
  output logic             wake_pending,
  output logic             sb_scl_out,
  output logic      [1:0]  mac_speed,
  output logic             mac_half_duplex,
  input  wire logic        frame_valid,
  input  wire logic [13:0] frame_len,
  input  wire logic        frame_uc_hit,
  input  wire logic        frame_bcast,
  input  wire logic        frame_mcast,
  input  wire logic [4:0]  frame_hash,
  input  wire logic        frame_rss_bit,
  output logic             frame_accept,
  output logic             frame_queue
);

  typedef struct packed {
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic        nvm_seen;
    logic        port_en;
    logic [1:0]  spd;
    logic        half;
    logic [1:0]  sb_sel;
    logic        unsupported_request_detected;
    logic [5:0]  pwr;
    logic        d3;
    logic [14:0] rxbuf;
    logic [5:0]  rx_kb;
    logic [4:0]  filt;
    logic [31:0] mta;
    logic        busy;
    logic [63:0] cur;
    logic [15:0] rem;
    logic        mv;
    logic [63:0] ma;
    logic [6:0]  ml;
    logic        cv;
    logic [2:0]  cs;
    logic        pass;
    logic [31:0] rdata;
    logic        sleep_n;
    logic        phypc;
    logic        g3_fresh;
    logic        hs;
    logic        sb;
    logic        wake;
    logic [1:0]  mspd;
    logic        mhalf;
    logic [6:0]  sbcnt;
    logic        scl;
    logic        acc;
    logic        q;
  } gpc_st_t;

  // synchronisers start at zero: no false wake, no early after-g3 clear
  localparam gpc_st_t ST_RST = '{
    spd: RST_SPD, rxbuf: RST_RXBUF, rx_kb: RST_RXKB, filt: RST_FILT,
    g3_fresh: 1'b1, phypc: 1'b1, scl: 1'b1,
    default: '0};

  // index of each synchronised pin
  localparam int P_S3 = 0;
  localparam int P_A  = 1;
  localparam int P_BT = 2;
  localparam int P_WK = 3;

  gpc_st_t s_ff;
  gpc_st_t nxt_s;

  logic       wr_hit;
  logic       srst;
  logic [6:0] room;
  logic [6:0] chunk;
  logic       load;
  logic       keep;
  logic [6:0] hp;
  logic [5:0] kb;

  // handshake and write decode
  assign req_ready = ~s_ff.busy;
  assign wr_hit    = reg_wr;
  assign srst      = reg_wr && (reg_addr == OFS_CTRL) && reg_wdata[CTRL_SRST];

  // next-state logic
  always_comb begin
    nxt_s = s_ff;
    kb    = 6'h00;
    // pins pass two flops before use
    nxt_s.sync1 = {~wake_n_pin, on_battery_pin, mgmt_sleep_n_n_pin, suspend_to_ram_sleep_n_n_pin};
    nxt_s.sync2 = s_ff.sync1;

    // nvm load done latches port setup once
    if (nvm_done && !s_ff.nvm_seen) begin
      nxt_s.nvm_seen = 1'b1;
      nxt_s.port_en  = nvm_port_en;
    end

    // register writes
    if (wr_hit) begin
      if (reg_addr == OFS_CTRL) begin
        nxt_s.spd    = reg_wdata[CTRL_SPD +: 2];
        nxt_s.half   = reg_wdata[CTRL_HALF];
        nxt_s.sb_sel = reg_wdata[CTRL_SB +: 2];
      end else if (reg_addr == OFS_PWR) begin
        nxt_s.pwr = reg_wdata[5:0];
      end else if (reg_addr == OFS_PM) begin
        nxt_s.d3 = reg_wdata[0];
      end else if (reg_addr == OFS_RXBUF) begin
        // clamp to legal buffer range
        if (reg_wdata[31:0] < 32'(RXBUF_MIN)) begin
          nxt_s.rxbuf = RXBUF_MIN;
        end else if (reg_wdata[31:0] > 32'(RXBUF_MAX)) begin
          nxt_s.rxbuf = RXBUF_MAX;
        end else begin
          nxt_s.rxbuf = reg_wdata[14:0];
        end
      end else if (reg_addr == OFS_FIFO) begin
        kb = (reg_wdata[31:0] > 32'(PBUF_KB)) ? PBUF_KB : reg_wdata[5:0];
        nxt_s.rx_kb = kb;
      end else if (reg_addr == OFS_FILT) begin
        nxt_s.filt = reg_wdata[4:0];
      end else if (reg_addr == OFS_MTA) begin
        nxt_s.mta = reg_wdata;
      end
    end

    // request splitter: chunks end on 64-byte lines and never cross 4 KB
    room  = MAX_REQ - {1'b0, s_ff.cur[5:0]};
    chunk = (s_ff.rem < 16'(room)) ? s_ff.rem[6:0] : room;
    load  = s_ff.busy && (!s_ff.mv || mem_ready);
    if (load) begin
      nxt_s.mv   = 1'b1;
      nxt_s.ma   = s_ff.cur;
      nxt_s.ml   = chunk;
      nxt_s.cur  = s_ff.cur + 64'(chunk);
      nxt_s.rem  = s_ff.rem - 16'(chunk);
      nxt_s.busy = (s_ff.rem != 16'(chunk));
    end else if (mem_ready) begin
      nxt_s.mv = 1'b0;
    end
    if (req_valid && !s_ff.busy && req_len != 16'h0000) begin
      nxt_s.busy = 1'b1;
      nxt_s.cur  = req_addr;
      nxt_s.rem  = req_len;
    end

    // incoming request checks
    nxt_s.cv   = 1'b0;
    nxt_s.cs   = CPL_SC;
    nxt_s.pass = 1'b0;
    if (rx_valid) begin
      if (rx_cfg && !s_ff.nvm_seen) begin
        nxt_s.cv = 1'b1;
        nxt_s.cs = CPL_CRS;
      end else if (rx_unsup || (!rx_cfg && s_ff.d3)) begin
        nxt_s.cv = rx_np;
        nxt_s.cs = CPL_UR;
      end else if (rx_bad) begin
        nxt_s.cv = rx_np;
        nxt_s.cs = CPL_CA;
      end else begin
        nxt_s.cv   = rx_np;
        nxt_s.pass = 1'b1;
      end
    end
    // flag set wins over software clear
    nxt_s.unsupported_request_detected = (s_ff.unsupported_request_detected & ~(wr_hit && reg_addr == OFS_ERROR_CONTROL_REG && reg_wdata[ERROR_CONTROL_REG_URD]))
              | (rx_valid && !(rx_cfg && !s_ff.nvm_seen)
                 && (rx_unsup || (!rx_cfg && s_ff.d3)));

    // phy supply control
    if (s_ff.sync2[P_S3]) begin
      nxt_s.g3_fresh = 1'b0;
    end
    keep = s_ff.sync2[P_S3] | s_ff.sync2[P_A]
         | s_ff.pwr[PWR_ME]
         | ((s_ff.pwr[PWR_SX] | (s_ff.pwr[PWR_AG3] & s_ff.g3_fresh))
            & ~(s_ff.pwr[PWR_DC] & s_ff.sync2[P_BT]));
    nxt_s.sleep_n = ~s_ff.pwr[PWR_DIS] & keep;
    nxt_s.phypc   = ~(s_ff.pwr[PWR_LOW] & nxt_s.sleep_n);

    // link and mode selection by system state
    nxt_s.hs   = (sys_state == SYS_S0) && s_ff.port_en;
    nxt_s.sb   = (sys_state == SYS_S0IX) || (sys_state == SYS_SX);
    nxt_s.wake = (sys_state != SYS_S0) && s_ff.sync2[P_WK];
    // speed code 3 counts as gigabit, so it too drops outside S0
    if (s_ff.spd >= SPD_1000 && sys_state != SYS_S0) begin
      nxt_s.mspd = SPD_100;
    end else if (s_ff.spd > SPD_1000) begin
      nxt_s.mspd = SPD_1000;
    end else begin
      nxt_s.mspd = s_ff.spd;
    end
    nxt_s.mhalf = s_ff.half && (nxt_s.mspd != SPD_1000);

    // sideband clock, one of three rates
    if (s_ff.sb_sel == 2'h1) begin
      hp = SB_HP1;
    end else if (s_ff.sb_sel == 2'h2) begin
      hp = SB_HP2;
    end else begin
      hp = SB_HP0;
    end
    if (!s_ff.sb) begin
      nxt_s.sbcnt = 7'h00;
      nxt_s.scl   = 1'b1;
    end else if (s_ff.sbcnt >= hp - 7'h01) begin
      nxt_s.sbcnt = 7'h00;
      nxt_s.scl   = ~s_ff.scl;
    end else begin
      nxt_s.sbcnt = s_ff.sbcnt + 7'h01;
    end

    // receive address filter and queue pick
    nxt_s.acc = frame_valid && (frame_len <= MAX_FRAME)
             && (s_ff.filt[FLT_PRM]
                 || (s_ff.filt[FLT_BC] && frame_bcast)
                 || (s_ff.filt[FLT_UC] && frame_uc_hit)
                 || (s_ff.filt[FLT_MC] && frame_mcast && s_ff.mta[frame_hash]));
    nxt_s.q = s_ff.filt[FLT_RSS] && frame_rss_bit;

    // read data, one cycle after the strobe
    nxt_s.rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == OFS_CTRL) begin
        nxt_s.rdata = {26'h0, s_ff.sb_sel, s_ff.half, s_ff.spd, 1'b0};
      end else if (reg_addr == OFS_STAT) begin
        nxt_s.rdata = {20'h0, s_ff.mspd, s_ff.mhalf, s_ff.phypc, s_ff.sleep_n, s_ff.busy,
                       s_ff.wake, s_ff.sb, s_ff.hs, s_ff.port_en, s_ff.nvm_seen, s_ff.g3_fresh};
      end else if (reg_addr == OFS_ERROR_CONTROL_REG) begin
        nxt_s.rdata = {31'h0, s_ff.unsupported_request_detected};
      end else if (reg_addr == OFS_PWR) begin
        nxt_s.rdata = {26'h0, s_ff.pwr};
      end else if (reg_addr == OFS_PM) begin
        nxt_s.rdata = {31'h0, s_ff.d3};
      end else if (reg_addr == OFS_RXBUF) begin
        nxt_s.rdata = {17'h0, s_ff.rxbuf};
      end else if (reg_addr == OFS_FIFO) begin
        nxt_s.rdata = {18'h0, PBUF_KB - s_ff.rx_kb, 2'h0, s_ff.rx_kb};
      end else if (reg_addr == OFS_FILT) begin
        nxt_s.rdata = {27'h0, s_ff.filt};
      end else if (reg_addr == OFS_MTA) begin
        nxt_s.rdata = s_ff.mta;
      end
    end

    // soft reset clears all but configuration space, the nvm port setup, the pin synchronisers and the after-g3 flag
    if (srst) begin
      nxt_s          = ST_RST;
      nxt_s.sync1    = s_ff.sync1;
      nxt_s.sync2    = s_ff.sync2;
      nxt_s.d3       = s_ff.d3;
      nxt_s.unsupported_request_detected      = s_ff.unsupported_request_detected;
      nxt_s.nvm_seen = s_ff.nvm_seen;
      nxt_s.port_en  = s_ff.port_en;
      nxt_s.g3_fresh = s_ff.g3_fresh;
    end
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_ff <= ST_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // outputs straight from flops
  assign reg_rdata             = s_ff.rdata;
  assign mem_valid             = s_ff.mv;
  assign mem_addr              = s_ff.ma;
  assign mem_len               = s_ff.ml;
  assign cpl_valid             = s_ff.cv;
  assign cpl_status            = s_ff.cs;
  assign rx_pass               = s_ff.pass;
  assign lan_phy_sleep_n       = s_ff.sleep_n;
  assign phy_power_control_out = s_ff.phypc;
  assign hs_link_active        = s_ff.hs;
  assign sb_link_active        = s_ff.sb;
  assign wake_pending          = s_ff.wake;
  assign sb_scl_out            = s_ff.scl;
  assign mac_speed             = s_ff.mspd;
  assign mac_half_duplex       = s_ff.mhalf;
  assign frame_accept          = s_ff.acc;
  assign frame_queue           = s_ff.q;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_chunk_max: assert property (mem_valid |-> mem_len <= MAX_REQ && mem_len != 7'h00)
    else $error("request chunk too long");
  a_page_cross: assert property (mem_valid |-> ({1'b0, mem_addr[11:0]} + 13'(mem_len)) <= PAGE_SZ)
    else $error("request crosses page");
  a_crs_early: assert property (rx_valid && rx_cfg && !s_ff.nvm_seen |=> cpl_valid && cpl_status == CPL_CRS)
    else $error("config not retried");
  a_abort_cpl: assert property (rx_valid && rx_np && !rx_cfg && !rx_unsup && !s_ff.d3 && rx_bad
                                |=> cpl_valid && cpl_status == CPL_CA && !rx_pass)
    else $error("missing completer abort");
  a_ur_flag: assert property (rx_valid && !rx_cfg && rx_unsup |=> s_ff.unsupported_request_detected ##1 (s_ff.unsupported_request_detected || $past(reg_wr)))
    else $error("unsupported flag not held");
  a_d3_block: assert property (rx_valid && !rx_cfg && s_ff.d3 |=> !rx_pass)
    else $error("access passed in D3");
  a_half_gig: assert property (mac_half_duplex |-> mac_speed != SPD_1000)
    else $error("half duplex at gigabit");
  a_gig_s0: assert property (mac_speed == SPD_1000 |-> $past(sys_state) == SYS_S0)
    else $error("gigabit outside S0");
  a_phy_power: assert property (s_ff.sync2[P_S3] && !s_ff.pwr[PWR_DIS] && !srst |=> lan_phy_sleep_n)
    else $error("phy unpowered while host runs");
  a_phypc_low: assert property (!phy_power_control_out |-> lan_phy_sleep_n)
    else $error("power control low while sleep low");
  a_jumbo_len: assert property (frame_accept |-> $past(frame_len) <= MAX_FRAME)
    else $error("oversize frame accepted");
  // completion, link, supply and queue checks
  a_ur_cpl: assert property (rx_valid && rx_np && !rx_cfg && rx_unsup
                             |=> cpl_valid && cpl_status == CPL_UR && !rx_pass)
    else $error("missing unsupported completion");
  a_hs_s0: assert property (hs_link_active |-> $past(sys_state) == SYS_S0)
    else $error("serial link outside S0");
  a_wake_sleep: assert property (wake_pending |-> $past(sys_state) != SYS_S0)
    else $error("wake reported in S0");
  a_scl_idle: assert property (!sb_link_active |=> sb_scl_out)
    else $error("sideband clock not idle high");
  a_dis_low: assert property (s_ff.pwr[PWR_DIS] |=> !lan_phy_sleep_n)
    else $error("sleep pin high while disabled");
  a_queue_rss: assert property (frame_queue |-> $past(frame_rss_bit))
    else $error("queue picked without hash bit");

  c_split: cover property (mem_valid && mem_ready ##1 mem_valid);
  c_retry: cover property (cpl_valid && cpl_status == CPL_CRS);
  c_sleep: cover property (sb_link_active && lan_phy_sleep_n && !phy_power_control_out);
  c_ur_cpl: cover property (cpl_valid && cpl_status == CPL_UR);
  c_gig_link: cover property (hs_link_active && mac_speed == SPD_1000);
endmodule

/* File: verification/gpc_phy_model.sv */
`timescale 1ns/1ns
// far-side phy: signals wake only while it is powered and not held in low power
module gpc_phy_model (
  input  wire logic lan_phy_sleep_n,
  input  wire logic phy_power_control_out,
  input  wire logic wake_req,
  output logic      wake_n_pin
);
  // wake line is pulled up, so a released or unpowered phy reads high
  assign wake_n_pin = (wake_req && lan_phy_sleep_n && phy_power_control_out) ? 1'h0 : 1'h1;
endmodule

/* File: verification/gpc_gbe_ctrl_tb_top.sv */
`timescale 1ns/1ns
module gpc_gbe_ctrl_tb_top
  import gpc_pkg::*;
;
  logic        clk_sys = 1'h0, rstn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, nvm_done = 1'h0, nvm_port_en = 1'h1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic        req_valid = 1'h0, req_ready, mem_valid, mem_ready = 1'h0;
  logic [63:0] req_addr = 64'h0, mem_addr;
  logic [15:0] req_len = 16'h0;
  logic [6:0]  mem_len;
  logic        rx_valid = 1'h0, rx_cfg = 1'h0, rx_np = 1'h0, rx_bad = 1'h0, rx_unsup = 1'h0, cpl_valid, rx_pass;
  logic [2:0]  cpl_status;
  logic [1:0]  sys_state = SYS_S0, mac_speed;
  logic        suspend_to_ram_sleep_n_n_pin = 1'h0, mgmt_sleep_n_n_pin = 1'h0, on_battery_pin = 1'h0, wake_n_pin, wake_req = 1'h0;
  logic        lan_phy_sleep_n, phy_power_control_out, hs_link_active, sb_link_active, wake_pending;
  logic        sb_scl_out, mac_half_duplex, frame_accept, frame_queue;
  logic        frame_valid = 1'h0, frame_uc_hit = 1'h0, frame_bcast = 1'h0, frame_mcast = 1'h0, frame_rss_bit = 1'h0;
  logic [13:0] frame_len = 14'h0;
  logic [4:0]  frame_hash = 5'h0;
  int          error_cnt = 0, cmp_count = 0;

  gpc_gbe_ctrl dut (
    .clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .nvm_done, .nvm_port_en,
    .req_valid, .req_addr, .req_len, .req_ready, .mem_valid, .mem_addr, .mem_len, .mem_ready,
    .rx_valid, .rx_cfg, .rx_np, .rx_bad, .rx_unsup, .cpl_valid, .cpl_status, .rx_pass,
    .sys_state, .suspend_to_ram_sleep_n_n_pin, .mgmt_sleep_n_n_pin, .on_battery_pin, .wake_n_pin, .lan_phy_sleep_n,
    .phy_power_control_out, .hs_link_active, .sb_link_active, .wake_pending, .sb_scl_out, .mac_speed,
    .mac_half_duplex, .frame_valid, .frame_len, .frame_uc_hit, .frame_bcast, .frame_mcast, .frame_hash,
    .frame_rss_bit, .frame_accept, .frame_queue);

  gpc_phy_model phy (.lan_phy_sleep_n, .phy_power_control_out, .wake_req, .wake_n_pin);

  // 20 MHz clock
  always #25 clk_sys = ~clk_sys;

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // register bus write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask

  // register bus read, data judged in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 chk("reg_rdata", exp, reg_rdata);
  endtask

  // incoming request and its completion
  task automatic rx(input logic c, np, bad, un, e_cpl, input logic [2:0] e_st, input logic e_pass);
    @(posedge clk_sys);
    rx_valid <= 1'h1;
    rx_cfg <= c;
    rx_np <= np;
    rx_bad <= bad;
    rx_unsup <= un;
    @(posedge clk_sys);
    rx_valid <= 1'h0;
    #1 chk("cpl_valid", e_cpl, cpl_valid);
    if (e_cpl) chk("cpl_status", e_st, cpl_status);
    chk("rx_pass", e_pass, rx_pass);
  endtask

  // dma request; chunks end on 64-byte lines, memory side stalls one cycle on the first chunk and two on each later one
  task automatic split(input logic [63:0] a, input int len);
    int n, k;
    @(posedge clk_sys);
    req_valid <= 1'h1;
    req_addr <= a;
    req_len <= 16'(len);
    @(posedge clk_sys);
    req_valid <= 1'h0;
    #1 chk("req_ready", 0, req_ready);
    while (len > 0) begin
      n = 64 - int'(a[5:0]);
      if (n > len) n = len;
      k = 0;
      do begin
        @(posedge clk_sys);
        #1 k++;
      end while (mem_valid !== 1'h1 && k < 50);
      chk("mem_addr", a, mem_addr);
      chk("mem_len", 64'(n), mem_len);
      @(posedge clk_sys);
      mem_ready <= 1'h1;
      @(posedge clk_sys);
      mem_ready <= 1'h0;
      a += 64'(n);
      len -= n;
    end
    #1 chk("mem_valid", 0, mem_valid);
    chk("req_ready", 1, req_ready);
  endtask

  // power enables and pins against the phy supply outputs
  task automatic pwr(input logic [5:0] p, input logic s3, a, bat, e_s, e_pc);
    wr(OFS_PWR, 32'(p));
    suspend_to_ram_sleep_n_n_pin <= s3;
    mgmt_sleep_n_n_pin <= a;
    on_battery_pin <= bat;
    settle(5);
    chk("lan_phy_sleep_n", e_s, lan_phy_sleep_n);
    chk("phy_power_control_out", e_pc, phy_power_control_out);
  endtask

  // system state against link choice, speed and wake
  task automatic link(input logic [1:0] st, input logic e_hs, e_sb, input logic [1:0] e_spd);
    @(posedge clk_sys);
    sys_state <= st;
    wake_req <= 1'h1;
    settle(6);
    chk("hs_link_active", e_hs, hs_link_active);
    chk("sb_link_active", e_sb, sb_link_active);
    chk("mac_speed", e_spd, mac_speed);
    chk("wake_pending", st != SYS_S0, wake_pending);
  endtask

  // sideband clock half period in system clocks
  task automatic scl(input logic [1:0] sel, input logic [6:0] hp);
    logic v;
    int k;
    wr(OFS_CTRL, {26'h0, sel, 4'h4});
    repeat (3) begin
      v = sb_scl_out;
      k = 0;
      while (sb_scl_out === v && k < 300) begin
        @(posedge clk_sys);
        #1 k++;
      end
    end
    chk("sb_scl_half", hp, k);
  endtask

  task automatic duplex(input logic [3:0] d, input logic [1:0] e_spd, input logic e_half);
    wr(OFS_CTRL, {28'h0, d});
    settle(2);
    chk("mac_speed", e_spd, mac_speed);
    chk("mac_half_duplex", e_half, mac_half_duplex);
  endtask

  task automatic frm(input int len, input logic u, b, m, input logic [4:0] h, input logic r, e_acc, e_q);
    @(posedge clk_sys);
    frame_valid <= 1'h1;
    frame_len <= 14'(len);
    frame_uc_hit <= u;
    frame_bcast <= b;
    frame_mcast <= m;
    frame_hash <= h;
    frame_rss_bit <= r;
    @(posedge clk_sys);
    frame_valid <= 1'h0;
    #1 chk("frame_accept", e_acc, frame_accept);
    if (e_acc) chk("frame_queue", e_q, frame_queue);
  endtask

  // mid-run reset with the port disabled in nvm; later pin changes are ignored
  task automatic port_off();
    @(posedge clk_sys);
    rstn <= 1'h0;
    nvm_port_en <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'h1;
    #1 chk("lan_phy_sleep_n", 0, lan_phy_sleep_n);
    settle(3);
    chk("hs_link_active", 0, hs_link_active);
    @(posedge clk_sys);
    nvm_port_en <= 1'h1;
    settle(2);
    chk("hs_link_active", 0, hs_link_active);
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    print_verdict();
  end

  // main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'h1;
    rd(OFS_CTRL, 32'h4);
    rd(OFS_RXBUF, 32'h800);
    rd(OFS_FIFO, 32'h1010);
    rd(OFS_FILT, 32'h5);
    rd(8'h40, 32'h0);
    rx(1, 1, 0, 0, 1, CPL_CRS, 0);
    rx(1, 0, 0, 0, 1, CPL_CRS, 0);
    @(posedge clk_sys);
    nvm_done <= 1'h1;
    settle(2);
    rx(1, 1, 0, 0, 1, CPL_SC, 1);
    rx(0, 1, 0, 1, 1, CPL_UR, 0);
    rx(0, 0, 0, 1, 0, CPL_SC, 0);
    rx(0, 1, 1, 0, 1, CPL_CA, 0);
    rx(0, 0, 1, 0, 0, CPL_SC, 0);
    rx(0, 1, 0, 0, 1, CPL_SC, 1);
    wr(OFS_PM, 32'h1);
    rx(0, 1, 0, 0, 1, CPL_UR, 0);
    rx(1, 1, 0, 0, 1, CPL_SC, 1);
    wr(OFS_PM, 32'h0);
    rx(0, 0, 0, 0, 0, CPL_SC, 1);
    wr(OFS_RXBUF, 32'h1000);
    wr(OFS_CTRL, 32'h1);
    rd(OFS_RXBUF, 32'h800);
    rd(OFS_ERROR_CONTROL_REG, 32'h1);
    wr(OFS_ERROR_CONTROL_REG, 32'h1);
    rd(OFS_ERROR_CONTROL_REG, 32'h0);
    wr(OFS_RXBUF, 32'h10);
    rd(OFS_RXBUF, 32'h100);
    wr(OFS_RXBUF, 32'h8000);
    rd(OFS_RXBUF, 32'h4000);
    wr(OFS_FIFO, 32'h8);
    rd(OFS_FIFO, 32'h1808);
    wr(OFS_FIFO, 32'h28);
    rd(OFS_FIFO, 32'h20);
    split(64'h3F0, 100);
    split(64'hFFF_FFF0, 200);
    pwr(6'h01, 0, 0, 0, 1, 1);
    pwr(6'h01, 1, 0, 0, 1, 1);
    pwr(6'h01, 0, 0, 0, 0, 1);
    pwr(6'h02, 0, 0, 0, 1, 1);
    pwr(6'h06, 0, 0, 1, 0, 1);
    pwr(6'h0E, 0, 0, 1, 1, 1);
    pwr(6'h00, 0, 1, 0, 1, 1);
    pwr(6'h20, 0, 1, 0, 1, 0);
    pwr(6'h30, 0, 1, 0, 0, 1);
    pwr(6'h00, 0, 1, 0, 1, 1);
    link(SYS_S0, 1, 0, SPD_1000);
    link(SYS_S0IX, 0, 1, SPD_100);
    scl(2'h0, SB_HP0);
    scl(2'h1, SB_HP1);
    scl(2'h2, SB_HP2);
    scl(2'h3, SB_HP0);
    link(SYS_SX, 0, 1, SPD_100);
    duplex(4'h6, SPD_100, 0);
    link(SYS_S0, 1, 0, SPD_1000);
    duplex(4'hA, SPD_100, 1);
    duplex(4'h8, SPD_10, 1);
    duplex(4'hC, SPD_1000, 0);
    frm(9018, 0, 1, 0, 0, 0, 1, 0);
    frm(9019, 0, 1, 0, 0, 0, 0, 0);
    frm(64, 1, 0, 0, 0, 0, 1, 0);
    frm(64, 0, 0, 1, 5, 0, 0, 0);
    wr(OFS_MTA, 32'h20);
    wr(OFS_FILT, 32'h12);
    frm(64, 0, 0, 1, 5, 1, 1, 1);
    frm(64, 0, 0, 1, 5, 0, 1, 0);
    frm(64, 0, 0, 1, 6, 0, 0, 0);
    frm(64, 1, 0, 0, 0, 0, 0, 0);
    wr(OFS_FILT, 32'h8);
    frm(64, 0, 0, 0, 0, 0, 1, 0);
    port_off();
    print_verdict();
  end
endmodule
